/* File: slr_cfg.svh */
// Register indices, field positions, reset values and timing figures of the routing block
`ifndef SLR_CFG_SVH
`define SLR_CFG_SVH

// Register indices; byte address is four times the index
`define SLR_IDX_MI_EN1       8'hF0
`define SLR_IDX_MI_CTRL2     8'hF1
`define SLR_IDX_MI_STAT1     8'hF2
`define SLR_IDX_MI_STAT2     8'hF3
`define SLR_IDX_MI_ROUTE     8'hF4
`define SLR_IDX_THERM_ROUTE  8'hF5
`define SLR_IDX_BEEP_ROUTE   8'hF6
`define SLR_IDX_KLOCK_ROUTE  8'hF7
`define SLR_IDX_LED1_ROUTE   8'hF8
`define SLR_IDX_LED1_CTRL    8'hF9
`define SLR_IDX_LED2_ROUTE   8'hFA
`define SLR_IDX_LED2_CTRL    8'hFB
`define SLR_IDX_VID_IN       8'hFC
`define SLR_IDX_VID_OUT      8'hFD
`define SLR_IDX_EVT_STAT     8'hE0
`define SLR_IDX_EVT_MASK     8'hE1

// Field positions
`define SLR_CTRL2_FCLR_BIT   7
`define SLR_CTRL2_LEVEL_BIT  6
`define SLR_VOLT_IDENT_OUT_EN_BIT       7
`define SLR_LOC_W            6
`define SLR_NUM_SRC1         8
`define SLR_NUM_SRC2         3
`define SLR_NUM_EVT          2
`define SLR_EVT_MI_BIT       0
`define SLR_EVT_VID_BIT      1

// Location code: set in bits 5..3, bit in set in 2..0
`define SLR_LOC_SET_MIN      3'h1
`define SLR_LOC_SET_MAX      3'h5
`define SLR_LOC_LAST_BIT     3'h5

// Reset values
`define SLR_RST_BYTE         8'h00
`define SLR_RST_LOC          6'h00

// Blink timebase: one tick is 1/8 s, all rates are multiples of it
`define SLR_CLK_PERIOD_NS    5
`define SLR_BLINK_TICK_NS    125000000

`endif

/* File: slr_pkg.sv */
// Types shared by the routing block
package slr_pkg;

	typedef struct packed {
		logic       short_pulse;
		logic [1:0] freq;
		logic       out_low;
	} slr_blink_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] idx;
	} slr_bus_req_t;

	typedef enum logic [1:0] {
		SLR_F4HZ,
		SLR_F1HZ,
		SLR_FQUARTER,
		SLR_FEIGHTH
	} slr_freq_t;

endpackage

/* File: slr_routing_regs.sv */
// Management interrupt, pin routing, blink LED and voltage-ident register block
// Summary of operation
// - Enable register 1 bits 4..0: environment, parallel, serial2, serial1, floppy enables.
// - Enable register 1 bits 7..5: music, pointing device, keyboard enables.
// - Writing one to control 2 bit 7 clears edge-mode status; bit reads back zero.
// - Control 2 bits 2..0 enable watchdog, infrared, panel button sources.
// - Two read-only status registers show per-source request state.
// - Interrupt pin route register bits 5..0 pick its pin; bits 7..6 reserved.
// - Thermal, beep and keyboard lock each have a 6-bit route, reset zero.
// - Each blink LED is routed by its own 6-bit location field.
// - Location code: upper three bits set 1..5, lower three bit (0..5 in set 5); others reserved.
// - LED control bits 2..1 pick 4 Hz, 1 Hz, 1/4 Hz or 1/8 Hz.
// - LED control bit 3 selects the short low pulse shape.
// - LED control bit 0 holds output low; bits 7..4 reserved.
// - Second LED control register matches the first, resets to zero.
// - Voltage-ident input register shows six pin levels, read-only.
// - Voltage-ident output bit 7 enables drive, bits 5..0 give values.
//
// Local design decision: the AHB-Lite register port.
`include "slr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module slr_routing_regs #(
	parameter int NUM_PINS    = 40,
	parameter int TICK_CYCLES = `SLR_BLINK_TICK_NS / `SLR_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       rstn,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	// Interrupt request sources, bits 10..0: watchdog..floppy
	input  wire logic [10:0]                src_irq,
	// Functions to route
	input  wire logic                       thermal_in,
	input  wire logic                       beep_in,
	input  wire logic                       kbd_lock_in,
	// Management interrupt, active low
	output logic                            mgmt_intr_n,
	// Routed GPIO pins, index (set-1)*8+bit
	output logic [NUM_PINS-1:0]             gpio_route_out,
	output logic [NUM_PINS-1:0]             gpio_route_oe,
	// Voltage-ident pins
	input  wire logic [5:0]                 volt_ident_in,
	output logic [5:0]                      volt_ident_out,
	output logic [5:0]                      volt_ident_out_en,
	// Block interrupt
	output logic                            irq
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave
	slr_pkg::slr_bus_req_t req_q;
	logic                  rd_pend_q;
	logic                  hready_q;
	logic [31:0]           hrdata_q;
	logic                  take;
	logic                  wr_now;
	logic [7:0]            wbyte;

	assign take   = hsel & htrans[1] & hready;
	assign wr_now = req_q.wr;
	assign wbyte  = hwdata[7:0];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_q     <= '0;
			rd_pend_q <= 1'b0;
			hready_q  <= 1'b1;
		end else begin
			req_q.wr  <= take & hwrite;
			req_q.rd  <= take & ~hwrite;
			req_q.idx <= take ? haddr[9:2] : req_q.idx;
			rd_pend_q <= take & ~hwrite;
			// Reads wait one cycle while the read byte is registered into hrdata_q
			hready_q  <= ~(take & ~hwrite);
		end
	end

	function automatic logic hit(input logic [7:0] idx);
		return wr_now && (req_q.idx == idx);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [7:0]                    en1_q;
	logic [6:0]                    ctrl2_q;
	logic [5:0]                    loc_q [6];
	slr_pkg::slr_blink_ctrl_t      led_q [2];
	logic [7:0]                    vid_out_q;
	logic [`SLR_NUM_EVT-1:0]       evt_mask_q;
	logic                          fclr;
	logic                          level_mode;
	logic [10:0]                   src_en;

	// Spelled out: a function's free variables would not wake a continuous assignment
	assign fclr       = wr_now & (req_q.idx == `SLR_IDX_MI_CTRL2) &
			wbyte[`SLR_CTRL2_FCLR_BIT];
	assign level_mode = ctrl2_q[`SLR_CTRL2_LEVEL_BIT];
	assign src_en     = {ctrl2_q[2:0], en1_q};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			en1_q      <= `SLR_RST_BYTE;
			ctrl2_q    <= '0;
			vid_out_q  <= `SLR_RST_BYTE;
			evt_mask_q <= '0;
			for (int i = 0; i < 6; i++) begin
				loc_q[i] <= `SLR_RST_LOC;
			end
			for (int i = 0; i < 2; i++) begin
				led_q[i] <= '0;
			end
		end else begin
			if (hit(`SLR_IDX_MI_EN1)) begin
				en1_q <= wbyte;
			end
			if (hit(`SLR_IDX_MI_CTRL2)) begin
				ctrl2_q <= {wbyte[6], 3'h0, wbyte[2:0]};
			end
			if (hit(`SLR_IDX_MI_ROUTE)) begin
				loc_q[0] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_THERM_ROUTE)) begin
				loc_q[1] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_BEEP_ROUTE)) begin
				loc_q[2] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_KLOCK_ROUTE)) begin
				loc_q[3] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_LED1_ROUTE)) begin
				loc_q[4] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_LED2_ROUTE)) begin
				loc_q[5] <= wbyte[5:0];
			end
			if (hit(`SLR_IDX_LED1_CTRL)) begin
				led_q[0] <= wbyte[3:0];
			end
			if (hit(`SLR_IDX_LED2_CTRL)) begin
				led_q[1] <= wbyte[3:0];
			end
			if (hit(`SLR_IDX_VID_OUT)) begin
				vid_out_q <= {wbyte[7], 1'b0, wbyte[5:0]};
			end
			if (hit(`SLR_IDX_EVT_MASK)) begin
				evt_mask_q <= wbyte[`SLR_NUM_EVT-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request status and management interrupt
	logic [10:0] src_q;
	logic [10:0] stat_q;
	logic [10:0] stat_d;
	logic [10:0] src_rise;
	logic        mi_act;
	logic        mi_act_q;
	logic        mi_n_q;

	assign src_rise = src_irq & ~src_q;
	// Edge mode latches rising requests; level mode follows the lines
	assign stat_d   = level_mode ? src_irq :
			(fclr ? src_rise : (stat_q | src_rise));
	assign mi_act   = |(stat_q & src_en);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_q    <= '0;
			stat_q   <= '0;
			mi_act_q <= 1'b0;
			mi_n_q   <= 1'b1;
		end else begin
			src_q    <= src_irq;
			stat_q   <= stat_d;
			mi_act_q <= mi_act;
			// Level: low while active; edge: one low cycle per rise
			mi_n_q   <= level_mode ? ~mi_act : ~(mi_act & ~mi_act_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Blink timebase
	logic [$clog2(TICK_CYCLES)-1:0] pre_q;
	logic [5:0]                     tick_q;
	logic                           tick;
	logic [1:0]                     led_wave;

	assign tick = (pre_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_q  <= '0;
			tick_q <= '0;
		end else begin
			pre_q  <= tick ? '0 : pre_q + 1'b1;
			tick_q <= tick ? tick_q + 1'b1 : tick_q;
		end
	end

	// Half-period in ticks: 1, 4, 16, 32; period is twice that
	function automatic logic blink(input slr_pkg::slr_blink_ctrl_t c, input logic [5:0] t);
		logic sq;
		logic start;
		sq    = 1'b0;
		start = 1'b0;
		case (slr_pkg::slr_freq_t'(c.freq))
			slr_pkg::SLR_F4HZ: begin
				sq    = t[0];
				start = ~t[0];
			end
			slr_pkg::SLR_F1HZ: begin
				sq    = t[2];
				start = (t[2:0] == 3'h0);
			end
			slr_pkg::SLR_FQUARTER: begin
				sq    = t[4];
				start = (t[4:0] == 5'h00);
			end
			slr_pkg::SLR_FEIGHTH: begin
				sq    = t[5];
				start = (t[5:0] == 6'h00);
			end
			default: begin
				sq    = 1'b0;
				start = 1'b0;
			end
		endcase
		if (c.out_low) begin
			return 1'b0;
		end
		return c.short_pulse ? ~start : sq;
	endfunction

	assign led_wave[0] = blink(led_q[0], tick_q);
	assign led_wave[1] = blink(led_q[1], tick_q);

	////////////////////////////////////////////////////////////////////////////
	// Pin routing
	logic [5:0]          fn_val;
	logic [NUM_PINS-1:0] route_out_d;
	logic [NUM_PINS-1:0] route_oe_d;
	logic [NUM_PINS-1:0] route_out_q;
	logic [NUM_PINS-1:0] route_oe_q;

	assign fn_val = {led_wave[1], led_wave[0], kbd_lock_in, beep_in, thermal_in, mi_n_q};

	// Reserved codes select no pin; a later function wins a shared pin
	function automatic logic loc_ok(input logic [5:0] loc);
		return (loc[5:3] >= `SLR_LOC_SET_MIN) && (loc[5:3] < `SLR_LOC_SET_MAX ||
			(loc[5:3] == `SLR_LOC_SET_MAX && loc[2:0] <= `SLR_LOC_LAST_BIT));
	endfunction

	always_comb begin
		route_out_d = '0;
		route_oe_d  = '0;
		for (int f = 0; f < 6; f++) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				if (loc_ok(loc_q[f]) && ({3'h0, loc_q[f]} - 9'd8 == 9'(p))) begin
					route_out_d[p] = fn_val[f];
					route_oe_d[p]  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			route_out_q <= '0;
			route_oe_q  <= '0;
		end else begin
			route_out_q <= route_out_d;
			route_oe_q  <= route_oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Block events and read path
	logic [5:0]              vid_q;
	logic [`SLR_NUM_EVT-1:0] evt_q;
	logic [`SLR_NUM_EVT-1:0] evt_set;
	logic                    evt_rdclr;
	logic                    irq_q;
	logic [7:0]              rd_byte;

	assign evt_set[`SLR_EVT_MI_BIT]  = mi_act & ~mi_act_q;
	assign evt_set[`SLR_EVT_VID_BIT] = |(vid_q ^ volt_ident_in);
	assign evt_rdclr = rd_pend_q && (req_q.idx == `SLR_IDX_EVT_STAT);

	always_comb begin
		case (req_q.idx)
			`SLR_IDX_MI_EN1:      rd_byte = en1_q;
			`SLR_IDX_MI_CTRL2:    rd_byte = {1'b0, ctrl2_q};
			`SLR_IDX_MI_STAT1:    rd_byte = stat_q[7:0];
			`SLR_IDX_MI_STAT2:    rd_byte = {5'h00, stat_q[10:8]};
			`SLR_IDX_MI_ROUTE:    rd_byte = {2'h0, loc_q[0]};
			`SLR_IDX_THERM_ROUTE: rd_byte = {2'h0, loc_q[1]};
			`SLR_IDX_BEEP_ROUTE:  rd_byte = {2'h0, loc_q[2]};
			`SLR_IDX_KLOCK_ROUTE: rd_byte = {2'h0, loc_q[3]};
			`SLR_IDX_LED1_ROUTE:  rd_byte = {2'h0, loc_q[4]};
			`SLR_IDX_LED2_ROUTE:  rd_byte = {2'h0, loc_q[5]};
			`SLR_IDX_LED1_CTRL:   rd_byte = {4'h0, led_q[0]};
			`SLR_IDX_LED2_CTRL:   rd_byte = {4'h0, led_q[1]};
			`SLR_IDX_VID_IN:      rd_byte = {2'h0, volt_ident_in};
			`SLR_IDX_VID_OUT:     rd_byte = vid_out_q;
			`SLR_IDX_EVT_STAT:    rd_byte = {6'h00, evt_q};
			`SLR_IDX_EVT_MASK:    rd_byte = {6'h00, evt_mask_q};
			default:              rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			vid_q    <= '0;
			evt_q    <= '0;
			irq_q    <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			vid_q    <= volt_ident_in;
			// New event wins over the read clear
			evt_q    <= (evt_rdclr ? '0 : evt_q) | evt_set;
			irq_q    <= |(evt_q & evt_mask_q);
			hrdata_q <= rd_pend_q ? {24'h00_0000, rd_byte} : hrdata_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hreadyout         = hready_q;
	assign hresp             = 1'b0;
	assign hrdata            = hrdata_q;
	assign mgmt_intr_n       = mi_n_q;
	assign gpio_route_out    = route_out_q;
	assign gpio_route_oe     = route_oe_q;
	assign volt_ident_out    = vid_out_q[5:0];
	assign volt_ident_out_en = {6{vid_out_q[`SLR_VOLT_IDENT_OUT_EN_BIT]}};
	assign irq               = irq_q;

endmodule

`default_nettype wire

/* File: slr_routing_regs_chk.sv */
// Property checker for the routing register block
`timescale 1ns/1ps
`default_nettype none
module slr_routing_regs_chk #(
	parameter int NUM_PINS = 40
) (
	// Clock and reset
	input wire logic                clock,
	input wire logic                rstn,
	// Bus
	input wire logic                hsel,
	input wire logic [31:0]         haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hwdata,
	input wire logic                hready,
	input wire logic                hreadyout,
	input wire logic [31:0]         hrdata,
	// Block pins
	input wire logic [10:0]         src_irq,
	input wire logic                mgmt_intr_n,
	input wire logic [NUM_PINS-1:0] gpio_route_oe,
	input wire logic [5:0]          volt_ident_out,
	input wire logic [5:0]          volt_ident_out_en
);
	logic        ph_q, w_q;
	logic [7:0]  ix_q, en_q, c2_q, mr_q, vo_q;
	logic [10:0] s1_q, s2_q;
	logic [1:0]  n_q;
	wire         tk = hsel && htrans[1] && hready;
	wire         dn = ph_q && hreadyout;
	wire         wd = dn && w_q;
	wire         rd = dn && !w_q;
	wire [5:0]   pin = {mr_q[5:3] - 3'h1, mr_q[2:0]};
	wire         ok = mr_q[5:3] != 3'h0 && mr_q[5:0] <= 6'h2D;
	////////////////////////////////////////
	// Shadow of written registers, settle counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			{ph_q, w_q, ix_q, en_q, c2_q, mr_q, vo_q, s1_q, s2_q, n_q} <= '0;
		end else begin
			ph_q <= tk || (ph_q && !hreadyout);
			if (tk) {w_q, ix_q} <= {hwrite, haddr[9:2]};
			if (wd && ix_q == 8'hF0) en_q <= hwdata[7:0];
			if (wd && ix_q == 8'hF1) c2_q <= hwdata[7:0];
			if (wd && ix_q == 8'hF4) mr_q <= hwdata[7:0];
			if (wd && ix_q == 8'hFD) vo_q <= hwdata[7:0];
			n_q <= wd ? 2'h0 : n_q + {1'h0, n_q != 2'h3};
			{s2_q, s1_q} <= {s1_q, src_irq};
		end
	end
	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_rd(a);
		rd && ix_q == a;
	endsequence
	property p_rd_wait; tk && !hwrite |=> s_wait; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_c2_rd; s_rd(8'hF1) |-> hrdata == {24'h0, c2_q & 8'h47}; endproperty
	a_c2_rd: assert property (p_c2_rd) else $error("control 2 wrong");
	property p_en1_rd; s_rd(8'hF0) |-> hrdata == {24'h0, en_q}; endproperty
	a_en1_rd: assert property (p_en1_rd) else $error("enable 1 wrong");
	property p_st2_rd; s_rd(8'hF3) |-> hrdata[31:3] == 29'h0; endproperty
	a_st2_rd: assert property (p_st2_rd) else $error("status 2 wrong");
	property p_rt_rd; s_rd(8'hF4) |-> hrdata == {26'h0, mr_q[5:0]}; endproperty
	a_rt_rd: assert property (p_rt_rd) else $error("route wrong");
	property p_vin_rd; s_rd(8'hFC) |-> hrdata[31:6] == 26'h0; endproperty
	a_vin_rd: assert property (p_vin_rd) else $error("vid in wrong");
	property p_vid;
		volt_ident_out_en == {6{vo_q[7]}} && volt_ident_out == vo_q[5:0];
	endproperty
	a_vid: assert property (p_vid) else $error("vid pins wrong");
	property p_level;
		n_q == 2'h3 && c2_q[6] |-> mgmt_intr_n == !(|(s2_q & {c2_q[2:0], en_q}));
	endproperty
	a_level: assert property (p_level) else $error("level output wrong");
	property p_edge; $fell(mgmt_intr_n) && !c2_q[6] |=> mgmt_intr_n; endproperty
	a_edge: assert property (p_edge) else $error("edge pulse wrong");
	property p_rt_oe; n_q == 2'h3 && ok |-> gpio_route_oe[pin]; endproperty
	a_rt_oe: assert property (p_rt_oe) else $error("route enable wrong");
endmodule
`default_nettype wire

/* File: tb_slr_routing_regs.sv */
// Self-checking bench for the routing register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected %s: expected %0h seen %0h", n, e, a); end end
module tb_slr_routing_regs;
	localparam int TK = 4;
	logic        clock = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic [1:0]  htrans = 2'h0;
	logic [10:0] src_irq = 11'h0;
	logic        thermal_in = 1'h0, beep_in = 1'h0, kbd_lock_in = 1'h0;
	logic [5:0]  volt_ident_in = 6'h0, volt_ident_out, volt_ident_out_en;
	logic        hreadyout, hresp, mgmt_intr_n, irq;
	logic [39:0] gpio_route_out, gpio_route_oe;
	wire         hready = hreadyout;
	wire  [2:0]  hsize = 3'h2;
	int          err_count = 0, checked = 0;
	always #2.5 clock = ~clock;
	slr_routing_regs #(.TICK_CYCLES(TK)) i_dut (.clock, .rstn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .src_irq, .thermal_in, .beep_in,
		.kbd_lock_in, .mgmt_intr_n, .gpio_route_out, .gpio_route_oe, .volt_ident_in,
		.volt_ident_out, .volt_ident_out_en, .irq);
	////////////////////////////////////////
	task automatic stop_test;
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic rdy;
		for (int i = 0; i < 50; i++) begin
			@(negedge clock);
			if (hreadyout === 1'h1) begin
				rv = hrdata;
				@(posedge clock);
				return;
			end
		end
		err_count++;
		stop_test();
	endtask
	task automatic xf(input logic w, input logic [7:0] ix, input logic [7:0] d);
		@(posedge clock);
		{hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, 22'h0, ix, 2'h0};
		rdy();
		{hsel, htrans, hwdata} <= {3'h0, 24'h0, d};
		rdy();
	endtask
	task automatic rc(input logic [7:0] ix, input logic [7:0] e, input string n);
		xf(1'h0, ix, 8'h0);
		`CHK(n, {24'h0, e}, rv)
		`CHK("hresp", 1'h0, hresp)
	endtask
	task automatic run(output int len, output logic lv);
		len = 0;
		@(negedge clock);
		lv = gpio_route_out[36];
		for (int i = 0; i < 300 && gpio_route_out[36] === lv; i++)
			@(negedge clock);
		lv = gpio_route_out[36];
		while (len < 300 && gpio_route_out[36] === lv) begin
			len++;
			@(negedge clock);
		end
	endtask
	////////////////////////////////////////
	task automatic s_reset;
		for (int i = 8'hF0; i <= 8'hFD; i++)
			if (i != 8'hFC) rc(i[7:0], 8'h0, "reset");
		xf(1'h1, 8'h10, 8'hFF);
		rc(8'h10, 8'h0, "unmapped");
	endtask
	task automatic s_route;
		logic [7:0]  c[6] = '{8'h08, 8'h11, 8'h1A, 8'h23, 8'h2C, 8'h2D};
		logic [7:0]  x[6] = '{8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hFA};
		logic [39:0] oe = 40'h0;
		logic [3:0]  pv;
		for (int i = 0; i < 6; i++) begin
			xf(1'h1, x[i], 8'hC0 | c[i]);
			rc(x[i], c[i], "route");
			oe[{c[i][5:3] - 3'h1, c[i][2:0]}] = 1'h1;
		end
		{thermal_in, beep_in, kbd_lock_in} <= 3'h5;
		repeat (3) @(negedge clock);
		`CHK("oe", oe, gpio_route_oe)
		pv = {gpio_route_out[0], gpio_route_out[9], gpio_route_out[18], gpio_route_out[27]};
		`CHK("out", 4'hD, pv)
		xf(1'h1, 8'hF5, 8'h2E);
		repeat (3) @(negedge clock);
		`CHK("reserved code", oe & ~40'h200, gpio_route_oe)
	endtask
	task automatic s_blink;
		int   hp[4] = '{1, 4, 16, 32};
		int   len;
		logic lv;
		xf(1'h1, 8'hFB, 8'hFF);
		rc(8'hFB, 8'h0F, "led2 ctrl");
		for (int f = 0; f < 4; f++) begin
			xf(1'h1, 8'hF9, {4'hF, 1'h0, f[1:0], 1'h0});
			run(len, lv);
			run(len, lv);
			`CHK("half period", TK * hp[f], len)
		end
		xf(1'h1, 8'hF9, 8'h0A);
		run(len, lv);
		run(len, lv);
		`CHK("short pulse", lv ? 7 * TK : TK, len)
		xf(1'h1, 8'hF9, 8'h01);
		run(len, lv);
		`CHK("held low", 33'h12C, {lv, len})
	endtask
	task automatic s_intr;
		int lo;
		xf(1'h1, 8'hF0, 8'hFF);
		xf(1'h1, 8'hF1, 8'h47);
		for (int i = 0; i < 11; i++) begin
			src_irq <= 11'h1 << i;
			repeat (3) @(negedge clock);
			`CHK("level out", 1'h0, mgmt_intr_n)
			rc(8'hF2, src_irq[7:0], "status 1");
			rc(8'hF3, {5'h0, src_irq[10:8]}, "status 2");
		end
		xf(1'h1, 8'hF0, 8'hFE);
		src_irq <= 11'h1;
		repeat (3) @(negedge clock);
		`CHK("disabled", 1'h1, mgmt_intr_n)
		xf(1'h1, 8'hF1, 8'h07);
		src_irq <= 11'h400;
		lo = 0;
		repeat (6) begin
			@(negedge clock);
			if (mgmt_intr_n === 1'h0) lo++;
		end
		`CHK("edge pulse", 1, lo)
		@(posedge clock);
		src_irq <= 11'h0;
		rc(8'hF3, 8'h04, "sticky");
		xf(1'h1, 8'hF1, 8'h87);
		rc(8'hF3, 8'h00, "force clear");
		rc(8'hF1, 8'h07, "clear bit");
		xf(1'h1, 8'hE1, 8'h01);
		repeat (2) @(negedge clock);
		`CHK("irq", 1'h1, irq)
		rc(8'hE0, 8'h01, "event");
		repeat (2) @(negedge clock);
		`CHK("irq cleared", 1'h0, irq)
	endtask
	task automatic s_vid;
		@(posedge clock);
		volt_ident_in <= 6'h2A;
		repeat (3) @(posedge clock);
		rc(8'hFC, 8'h2A, "vid in");
		repeat (2) @(negedge clock);
		`CHK("irq masked", 1'h0, irq)
		xf(1'h1, 8'hE1, 8'h03);
		xf(1'h1, 8'hFD, 8'hFF);
		rc(8'hFD, 8'hBF, "vid out");
		@(negedge clock);
		`CHK("vid pins", 13'h1FFF, {irq, volt_ident_out, volt_ident_out_en})
		rc(8'hE0, 8'h02, "vid event");
		xf(1'h1, 8'hFD, 8'h15);
		@(negedge clock);
		`CHK("vid input mode", 12'h015, {volt_ident_out_en, volt_ident_out})
	endtask
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'h1;
		repeat (3) @(posedge clock);
		s_reset();
		s_route();
		s_blink();
		s_intr();
		s_vid();
		stop_test();
	end
endmodule
bind slr_routing_regs slr_routing_regs_chk #(.NUM_PINS(NUM_PINS)) i_chk (.clock, .rstn, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .src_irq, .mgmt_intr_n,
	.gpio_route_oe, .volt_ident_out, .volt_ident_out_en);
`default_nettype wire
